// ===== hdl/aosm_matrix.sv
/*
 * Output source matrix and level stage: picks the decoded source for the
 * serial audio port and for the mono converter, applies the left/right
 * matrix and the level or converter gain, and holds the three control
 * registers reached by subaddress.
 * Assumes a control bus front end that issues one-cycle write and read
 * strobes with a subaddress, and sample and identification inputs that
 * come from logic on the same clock.
 */
// Overview of operation
// - Serial select register resets to all zeros
// - Auto-select needs auto bit and ident switch
// - Manual modes map L/R, L/L, R/R, R/L, sum
// - Source field picks FM, NICAM, or mixed pairs
// - Auto matrix only for source codes 00, 01
// - Auto modes: M/M, L/R, A/A or B/B, FM A/A on mute
// - FM serial source follows FM dematrix switching
// - Level: +N dB, or nibble minus 15 dB
// - Same level applied to left and right
// - Mono converter always uses automatic matrix
// - Stereo reception feeds half-sum to mono converter
// - Second language only during dual reception
// - FM dematrix settings ignored by mono path
// - Mono converter gain 0, 3, 6, 9 dB
// - Mono source FM or NICAM, A or B
`timescale 1ns/1ps
module aosm_matrix (
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    reg_wr_en_in,
  input  wire logic                    reg_rd_en_in,
  input  wire logic              [7:0] reg_addr_in,
  input  wire logic              [7:0] reg_wdata_in,
  output logic                   [7:0] reg_rdata_out,
  input  wire aosm_pkg::aosm_samples_t samples_in,
  input  wire logic                    sample_valid_in,
  input  wire aosm_pkg::aosm_ident_t   ident_in,
  output aosm_pkg::aosm_audio_t        audio_out,
  output logic                         audio_valid_out,
  output logic                         serial_auto_active_out
);

  aosm_pkg::aosm_state_t state_reg;
  aosm_pkg::aosm_state_t state_next;

  // Register fields
  logic       serial_out_auto_select;
  logic [2:0] serial_out_channel_mode;
  logic [1:0] serial_out_source;
  logic [4:0] level_code;
  logic [1:0] mono_conv_gain;
  logic [1:0] mono_conv_source;

  assign serial_out_auto_select = state_reg.ser_sel[aosm_pkg::POS_AUTO];
  assign serial_out_channel_mode =
    state_reg.ser_sel[aosm_pkg::POS_MODE_LSB +: 3];
  assign serial_out_source = state_reg.ser_sel[aosm_pkg::POS_SRC_LSB +: 2];
  assign level_code        = state_reg.ser_lvl[4:0];
  assign mono_conv_gain    = {state_reg.mono_sel[aosm_pkg::POS_MGAIN_B1],
                              state_reg.mono_sel[aosm_pkg::POS_MGAIN_B0]};
  assign mono_conv_source  =
    state_reg.mono_sel[aosm_pkg::POS_MSRC_LSB +: 2];

  function automatic logic signed [15:0] half_sum(
    input logic signed [15:0] a,
    input logic signed [15:0] b
  );
    logic signed [16:0] s;
    s = {a[15], a} + {b[15], b};
    return s[16:1];
  endfunction : half_sum

  // Reception mode from the identification flags
  aosm_pkg::aosm_sound_t fm_sound;
  aosm_pkg::aosm_sound_t nicam_sound;

  always_comb begin
    if (ident_in.fm_dual_detected) begin
      fm_sound = aosm_pkg::AOSM_SND_DUAL;
    end else if (ident_in.fm_stereo_detected) begin
      fm_sound = aosm_pkg::AOSM_SND_STEREO;
    end else begin
      fm_sound = aosm_pkg::AOSM_SND_MONO;
    end
    if (ident_in.digital_dual_flag) begin
      nicam_sound = aosm_pkg::AOSM_SND_DUAL;
    end else if (ident_in.digital_stereo_flag) begin
      nicam_sound = aosm_pkg::AOSM_SND_STEREO;
    end else begin
      nicam_sound = aosm_pkg::AOSM_SND_MONO;
    end
  end

  // Serial pair before the matrix
  logic signed [15:0] src_l;
  logic signed [15:0] src_r;

  always_comb begin
    // FM left/right are taken after the dematrix switching
    src_l = samples_in.fm_l;
    src_r = samples_in.fm_r;
    case (serial_out_source)
      aosm_pkg::SRC_FM: begin
        src_l = samples_in.fm_l;
        src_r = samples_in.fm_r;
      end
      aosm_pkg::SRC_NICAM: begin
        src_l = samples_in.nicam_l;
        src_r = samples_in.nicam_r;
      end
      aosm_pkg::SRC_FM_NIC_1: begin
        src_l = samples_in.fm_l;
        src_r = samples_in.nicam_l;
      end
      aosm_pkg::SRC_FM_NIC_2: begin
        src_l = samples_in.fm_l;
        src_r = samples_in.nicam_r;
      end
      default: begin
        src_l = samples_in.fm_l;
        src_r = samples_in.fm_r;
      end
    endcase
  end

  // Automatic matrix condition for the serial port
  logic auto_active;
  logic fm_mute_override;

  assign auto_active = serial_out_auto_select &&
                       ident_in.fm_ident_switch_enable &&
                       !serial_out_source[1];
  assign fm_mute_override = ident_in.auto_mute &&
    (ident_in.second_channel_mode == aosm_pkg::SEC_CH_FM_MUTE);

  logic signed [15:0] ser_l;
  logic signed [15:0] ser_r;
  aosm_pkg::aosm_sound_t ser_sound;
  logic signed [15:0] mono_a;
  logic signed [15:0] mono_b;

  always_comb begin
    ser_l = src_l;
    ser_r = src_r;
    if (serial_out_source == aosm_pkg::SRC_NICAM) begin
      ser_sound = nicam_sound;
      mono_a    = samples_in.nicam_l;
      mono_b    = samples_in.nicam_r;
    end else begin
      ser_sound = fm_sound;
      mono_a    = samples_in.fm_a;
      mono_b    = samples_in.fm_b;
    end
    if (auto_active) begin
      if (fm_mute_override) begin
        ser_l = samples_in.fm_a;
        ser_r = samples_in.fm_a;
      end else begin
        case (ser_sound)
          aosm_pkg::AOSM_SND_MONO: begin
            ser_l = mono_a;
            ser_r = mono_a;
          end
          aosm_pkg::AOSM_SND_STEREO: begin
            ser_l = src_l;
            ser_r = src_r;
          end
          aosm_pkg::AOSM_SND_DUAL: begin
            if (serial_out_channel_mode == aosm_pkg::MODE_RR) begin
              ser_l = mono_b;
              ser_r = mono_b;
            end else begin
              ser_l = mono_a;
              ser_r = mono_a;
            end
          end
          default: begin
            ser_l = src_l;
            ser_r = src_r;
          end
        endcase
      end
    end else begin
      case (serial_out_channel_mode)
        aosm_pkg::MODE_LR: begin
          ser_l = src_l;
          ser_r = src_r;
        end
        aosm_pkg::MODE_LL: begin
          ser_l = src_l;
          ser_r = src_l;
        end
        aosm_pkg::MODE_RR: begin
          ser_l = src_r;
          ser_r = src_r;
        end
        aosm_pkg::MODE_RL: begin
          ser_l = src_r;
          ser_r = src_l;
        end
        aosm_pkg::MODE_SUM: begin
          ser_l = half_sum(src_l, src_r);
          ser_r = half_sum(src_l, src_r);
        end
        default: begin
          ser_l = src_l;
          ser_r = src_r;
        end
      endcase
    end
  end

  // Mono converter: always automatic, FM taken before the dematrix
  logic signed [15:0] mono_pick;

  always_comb begin
    mono_pick = samples_in.fm_a;
    case (mono_conv_source)
      aosm_pkg::MSRC_FM_A, aosm_pkg::MSRC_FM_B: begin
        if (fm_sound == aosm_pkg::AOSM_SND_DUAL &&
            mono_conv_source == aosm_pkg::MSRC_FM_B) begin
          mono_pick = samples_in.fm_b;
        end else begin
          // Channel one carries mono, dual A, or the half-sum
          mono_pick = samples_in.fm_a;
        end
      end
      aosm_pkg::MSRC_NIC_A, aosm_pkg::MSRC_NIC_B: begin
        if (nicam_sound == aosm_pkg::AOSM_SND_STEREO) begin
          mono_pick = half_sum(samples_in.nicam_l,
                               samples_in.nicam_r);
        end else if (nicam_sound == aosm_pkg::AOSM_SND_DUAL &&
                     mono_conv_source == aosm_pkg::MSRC_NIC_B) begin
          mono_pick = samples_in.nicam_r;
        end else begin
          mono_pick = samples_in.nicam_l;
        end
      end
      default: mono_pick = samples_in.fm_a;
    endcase
  end

  // Gain factors
  logic [14:0] level_factor;
  logic [14:0] mono_factor;

  always_comb begin
    if (!level_code[aosm_pkg::POS_LVL_NEG]) begin
      level_factor = aosm_pkg::aosm_db_factor(int'(level_code[3:0]));
    end else if (level_code[3:0] == aosm_pkg::LVL_NIBBLE_UNDEF) begin
      level_factor = aosm_pkg::GAIN_UNITY;
    end else begin
      level_factor = aosm_pkg::aosm_db_factor(
        int'(level_code[3:0]) - int'(aosm_pkg::LVL_NEG_OFFSET));
    end
    mono_factor = aosm_pkg::aosm_db_factor(3 * int'(mono_conv_gain));
  end

  // Registers, read-back and the picked samples
  always_comb begin
    state_next = state_reg;
    if (reg_wr_en_in) begin
      case (reg_addr_in)
        aosm_pkg::ADDR_SER_SEL: begin
          state_next.ser_sel = reg_wdata_in & aosm_pkg::MASK_SER_SEL;
        end
        aosm_pkg::ADDR_SER_LVL: begin
          state_next.ser_lvl = reg_wdata_in & aosm_pkg::MASK_SER_LVL;
        end
        aosm_pkg::ADDR_MONO_SEL: begin
          state_next.mono_sel = reg_wdata_in & aosm_pkg::MASK_MONO_SEL;
        end
        default: state_next.ser_sel = state_reg.ser_sel;
      endcase
    end
    if (reg_rd_en_in) begin
      case (reg_addr_in)
        aosm_pkg::ADDR_SER_SEL:  state_next.rdata = state_reg.ser_sel;
        aosm_pkg::ADDR_SER_LVL:  state_next.rdata = state_reg.ser_lvl;
        aosm_pkg::ADDR_MONO_SEL: state_next.rdata = state_reg.mono_sel;
        default: state_next.rdata = aosm_pkg::RDATA_UNMAPPED;
      endcase
    end
    state_next.pick_valid  = sample_valid_in;
    state_next.auto_active = auto_active;
    if (sample_valid_in) begin
      state_next.pick.left  = ser_l;
      state_next.pick.right = ser_r;
      state_next.pick.mono  = mono_pick;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg          <= '0;
      state_reg.ser_sel  <= aosm_pkg::RST_SER_SEL;
      state_reg.ser_lvl  <= aosm_pkg::RST_SER_LVL;
      state_reg.mono_sel <= aosm_pkg::RST_MONO_SEL;
    end else begin
      state_reg <= state_next;
    end
  end

  // Gain stages: left, right with the level, mono with converter gain
  logic signed [15:0] stage_in  [3];
  logic        [14:0] stage_fac [3];
  logic signed [15:0] stage_out [3];
  logic               stage_vld [3];

  assign stage_in[0]  = state_reg.pick.left;
  assign stage_in[1]  = state_reg.pick.right;
  assign stage_in[2]  = state_reg.pick.mono;
  assign stage_fac[0] = level_factor;
  assign stage_fac[1] = level_factor;
  assign stage_fac[2] = mono_factor;

  for (genvar ch = 0; ch < 3; ch++) begin : g_gain
    aosm_gain_stage u_gain (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .sample_in  (stage_in[ch]),
      .valid_in   (state_reg.pick_valid),
      .factor_in  (stage_fac[ch]),
      .sample_out (stage_out[ch]),
      .valid_out  (stage_vld[ch])
    );
  end

  assign audio_out.left         = stage_out[0];
  assign audio_out.right        = stage_out[1];
  assign audio_out.mono         = stage_out[2];
  assign audio_valid_out        = stage_vld[0];
  assign reg_rdata_out          = state_reg.rdata;
  assign serial_auto_active_out = state_reg.auto_active;

endmodule : aosm_matrix

// ===== hdl/aosm_pkg.sv
/*
 * Shared constants, field layouts, codes and carrier types for the
 * audio output source matrix (serial audio port and mono converter).
 * Assumes one system clock; all producers of samples and flags share it.
 */
package aosm_pkg;

  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned GAIN_W   = 15;
  localparam int unsigned GAIN_FRAC = 12;

  // Register subaddresses
  localparam logic [7:0] ADDR_SER_SEL  = 8'h16;
  localparam logic [7:0] ADDR_SER_LVL  = 8'h17;
  localparam logic [7:0] ADDR_MONO_SEL = 8'h18;

  // Values after power-on reset
  localparam logic [7:0] RST_SER_SEL  = 8'h00;
  localparam logic [7:0] RST_SER_LVL  = 8'h00;
  localparam logic [7:0] RST_MONO_SEL = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'hFF;

  // Implemented bits; the rest read as zero
  localparam logic [7:0] MASK_SER_SEL  = 8'hF3;
  localparam logic [7:0] MASK_SER_LVL  = 8'h1F;
  localparam logic [7:0] MASK_MONO_SEL = 8'h8B;

  // Field positions
  localparam int unsigned POS_AUTO     = 7;
  localparam int unsigned POS_MODE_LSB = 4;
  localparam int unsigned POS_SRC_LSB  = 0;
  localparam int unsigned POS_LVL_NEG  = 4;
  localparam int unsigned POS_MGAIN_B1 = 7;
  localparam int unsigned POS_MGAIN_B0 = 3;
  localparam int unsigned POS_MSRC_LSB = 0;

  // Serial source codes
  localparam logic [1:0] SRC_FM       = 2'h0;
  localparam logic [1:0] SRC_NICAM    = 2'h1;
  localparam logic [1:0] SRC_FM_NIC_1 = 2'h2;
  localparam logic [1:0] SRC_FM_NIC_2 = 2'h3;

  // Channel mode codes
  localparam logic [2:0] MODE_LR  = 3'h0;
  localparam logic [2:0] MODE_LL  = 3'h1;
  localparam logic [2:0] MODE_RR  = 3'h2;
  localparam logic [2:0] MODE_RL  = 3'h3;
  localparam logic [2:0] MODE_SUM = 3'h4;

  // Mono converter source codes
  localparam logic [1:0] MSRC_FM_A  = 2'h0;
  localparam logic [1:0] MSRC_FM_B  = 2'h1;
  localparam logic [1:0] MSRC_NIC_A = 2'h2;
  localparam logic [1:0] MSRC_NIC_B = 2'h3;

  localparam logic [1:0] SEC_CH_FM_MUTE = 2'h2;
  localparam logic [3:0] LVL_NIBBLE_UNDEF = 4'hF;
  localparam logic [3:0] LVL_NEG_OFFSET   = 4'hF;

  // Unity gain in the fixed point factor
  localparam logic [14:0] GAIN_UNITY = 15'h1000;

  typedef enum {AOSM_SND_MONO, AOSM_SND_STEREO, AOSM_SND_DUAL} aosm_sound_t;

  typedef struct packed {
    logic signed [15:0] fm_l;
    logic signed [15:0] fm_r;
    logic signed [15:0] fm_a;
    logic signed [15:0] fm_b;
    logic signed [15:0] nicam_l;
    logic signed [15:0] nicam_r;
  } aosm_samples_t;

  typedef struct packed {
    logic       fm_ident_switch_enable;
    logic       fm_stereo_detected;
    logic       fm_dual_detected;
    logic       digital_stereo_flag;
    logic       digital_dual_flag;
    logic       auto_mute;
    logic [1:0] second_channel_mode;
  } aosm_ident_t;

  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
    logic signed [15:0] mono;
  } aosm_audio_t;

  typedef struct packed {
    logic [7:0]  ser_sel;
    logic [7:0]  ser_lvl;
    logic [7:0]  mono_sel;
    logic [7:0]  rdata;
    aosm_audio_t pick;
    logic        pick_valid;
    logic        auto_active;
  } aosm_state_t;

  typedef struct packed {
    logic signed [15:0] sample;
    logic               valid;
  } aosm_gain_state_t;

  // Linear factor for a whole dB step, 12 fractional bits
  function automatic logic [14:0] aosm_db_factor(input int db);
    logic [14:0] f;
    f = GAIN_UNITY;
    case (db)
      -15: f = 15'h02D8;
      -14: f = 15'h0331;
      -13: f = 15'h0395;
      -12: f = 15'h0405;
      -11: f = 15'h0482;
      -10: f = 15'h050F;
      -9:  f = 15'h05AD;
      -8:  f = 15'h065F;
      -7:  f = 15'h0726;
      -6:  f = 15'h0805;
      -5:  f = 15'h08FF;
      -4:  f = 15'h0A18;
      -3:  f = 15'h0B54;
      -2:  f = 15'h0CB6;
      -1:  f = 15'h0E43;
      1:   f = 15'h11F4;
      2:   f = 15'h1425;
      3:   f = 15'h169A;
      4:   f = 15'h195C;
      5:   f = 15'h1C74;
      6:   f = 15'h1FED;
      7:   f = 15'h23D2;
      8:   f = 15'h2831;
      9:   f = 15'h2D18;
      10:  f = 15'h3299;
      11:  f = 15'h38C5;
      12:  f = 15'h3FB2;
      13:  f = 15'h4778;
      14:  f = 15'h5031;
      15:  f = 15'h59FA;
      default: f = GAIN_UNITY;
    endcase
    return f;
  endfunction : aosm_db_factor

endpackage : aosm_pkg

// ===== hdl/aosm_gain_stage.sv
/*
 * One channel of fixed point gain: sample times factor, rounded down,
 * saturated to the sample width, registered.
 * Assumes the factor is stable while valid samples pass.
 */
`timescale 1ns/1ps
module aosm_gain_stage (
  input  wire logic               sys_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic signed [15:0] sample_in,
  input  wire logic               valid_in,
  input  wire logic        [14:0] factor_in,
  output logic signed      [15:0] sample_out,
  output logic                    valid_out
);

  aosm_pkg::aosm_gain_state_t state_reg;
  aosm_pkg::aosm_gain_state_t state_next;

  logic signed [31:0] product;
  logic signed [19:0] scaled;

  always_comb begin
    state_next = state_reg;
    product    = sample_in * $signed({1'b0, factor_in});
    scaled     = product[31:aosm_pkg::GAIN_FRAC];
    state_next.valid = valid_in;
    if (valid_in) begin
      // Clip instead of wrapping on large boosts
      if (scaled > 20'sh07FFF) begin
        state_next.sample = 16'sh7FFF;
      end else if (scaled < -20'sh08000) begin
        state_next.sample = -16'sh8000;
      end else begin
        state_next.sample = scaled[15:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sample_out = state_reg.sample;
  assign valid_out  = state_reg.valid;

endmodule : aosm_gain_stage

// ===== tb/aosm_audio_sink.sv
/*
 * Receiver model for the matrix output: keeps the last sample set that
 * was marked valid and counts the sets received.
 * Assumes the same system clock and reset as the matrix.
 */
`timescale 1ns/1ps
module aosm_audio_sink (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_n_in,
  input  wire aosm_pkg::aosm_audio_t audio_in,
  input  wire logic                  valid_in,
  output aosm_pkg::aosm_audio_t      last_out,
  output logic [15:0]                count_out
);
  // Only marked samples are taken
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_out  <= '0;
      count_out <= 16'h0000;
    end else if (valid_in) begin
      last_out  <= audio_in;
      count_out <= count_out + 16'h0001;
    end
  end
endmodule : aosm_audio_sink

// ===== tb/aosm_checker.sv
/*
 * Concurrent checks on the matrix ports: bus answers, sample latency
 * and the plain routing cases, with shadow copies of the registers.
 * Assumes it is bound to the matrix top and sees only its ports.
 */
`timescale 1ns/1ps
module aosm_checker (
  input wire logic                    sys_clk_in,
  input wire logic                    rst_n_in,
  input wire logic                    reg_wr_en_in,
  input wire logic                    reg_rd_en_in,
  input wire logic              [7:0] reg_addr_in,
  input wire logic              [7:0] reg_wdata_in,
  input wire logic              [7:0] reg_rdata_out,
  input wire aosm_pkg::aosm_samples_t samples_in,
  input wire logic                    sample_valid_in,
  input wire aosm_pkg::aosm_ident_t   ident_in,
  input wire aosm_pkg::aosm_audio_t   audio_out,
  input wire logic                    audio_valid_out,
  input wire logic                    serial_auto_active_out
);
  logic [7:0] sh_sel_reg;
  logic [7:0] sh_lvl_reg;
  logic [7:0] sh_mono_reg;

  // Register contents as written over the bus
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sh_sel_reg  <= 8'h00;
      sh_lvl_reg  <= 8'h00;
      sh_mono_reg <= 8'h00;
    end else if (reg_wr_en_in) begin
      if (reg_addr_in == 8'h16) sh_sel_reg <= reg_wdata_in & 8'hF3;
      if (reg_addr_in == 8'h17) sh_lvl_reg <= reg_wdata_in & 8'h1F;
      if (reg_addr_in == 8'h18) sh_mono_reg <= reg_wdata_in & 8'h8B;
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_valid_latency: assert property (
    sample_valid_in |-> ##2 audio_valid_out) else $error("late output");
  a_valid_cause: assert property (
    audio_valid_out |-> $past(sample_valid_in, 2)) else $error("stray valid");
  a_unmapped_read: assert property (reg_rd_en_in &&
    !(reg_addr_in inside {8'h16, 8'h17, 8'h18}) |=> reg_rdata_out == 8'hFF)
    else $error("unmapped read data");
  a_rdata_holds: assert property (
    !reg_rd_en_in |=> $stable(reg_rdata_out)) else $error("read data moved");
  a_sel_readback: assert property (reg_rd_en_in &&
    reg_addr_in == 8'h16 |=> reg_rdata_out == $past(sh_sel_reg))
    else $error("select register read");
  a_lvl_readback: assert property (reg_rd_en_in &&
    reg_addr_in == 8'h17 |=> reg_rdata_out == $past(sh_lvl_reg))
    else $error("level register read");
  a_mono_readback: assert property (
    reg_rd_en_in && reg_addr_in == 8'h18
    |=> reg_rdata_out == $past(sh_mono_reg)) else $error("mono register read");
  a_manual_straight: assert property (
    sample_valid_in && sh_sel_reg == 8'h00 && sh_lvl_reg == 8'h00 |-> ##2
    audio_out.left == $past(samples_in.fm_l, 2) &&
    audio_out.right == $past(samples_in.fm_r, 2)) else $error("straight map");
  a_equal_sides: assert property (
    sample_valid_in && sh_sel_reg[7:4] == 4'h1 |-> ##2
    audio_out.left == audio_out.right) else $error("sides differ");
  a_mono_default: assert property (
    sample_valid_in && sh_mono_reg == 8'h00 |-> ##2
    audio_out.mono == $past(samples_in.fm_a, 2)) else $error("mono source");
  a_lang_gate: assert property (
    sample_valid_in && sh_mono_reg == 8'h01 && !ident_in.fm_dual_detected
    |-> ##2 audio_out.mono == $past(samples_in.fm_a, 2))
    else $error("second language leaked");

  c_auto_sample: cover property (audio_valid_out && serial_auto_active_out);
  c_unmapped: cover property (reg_rd_en_in && reg_addr_in == 8'h20);
  c_mono_gain: cover property (sample_valid_in && sh_mono_reg[7]);
endmodule : aosm_checker

bind aosm_matrix aosm_checker u_chk (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .reg_wr_en_in(reg_wr_en_in),
  .reg_rd_en_in(reg_rd_en_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .samples_in(samples_in), .sample_valid_in(sample_valid_in),
  .ident_in(ident_in), .audio_out(audio_out),
  .audio_valid_out(audio_valid_out),
  .serial_auto_active_out(serial_auto_active_out));

// ===== tb/test_audio_output_source_matrix.sv
/*
 * Self-checking bench for the output source matrix: register access,
 * manual and automatic serial matrix, level and mono converter path.
 * Assumes the design package, the matrix and the sink model are built.
 */
`timescale 1ns/1ps
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("wrong value at %0t: %s", $time, m); end end
module test_audio_output_source_matrix;
  typedef logic signed [15:0] aosm_tb_smp_t;
  localparam aosm_tb_smp_t FL = 16'h0100;
  localparam aosm_tb_smp_t FR = 16'hFE00;
  localparam aosm_tb_smp_t FA = 16'h0300;
  localparam aosm_tb_smp_t FB = 16'hFC00;
  localparam aosm_tb_smp_t NL = 16'h0500;
  localparam aosm_tb_smp_t NR = 16'h0700;
  localparam aosm_tb_smp_t ML [8] = '{FL, FL, FR, FR, 16'hFF80, FL, FL, FL};
  localparam aosm_tb_smp_t MR [8] = '{FR, FL, FR, FL, 16'hFF80, FR, FR, FR};
  localparam aosm_tb_smp_t SL [4] = '{FL, NL, FL, FL};
  localparam aosm_tb_smp_t SR [4] = '{FR, NR, NL, NR};
  localparam logic [7:0] AS [12] = '{8'h80, 8'h80, 8'h80, 8'hA0, 8'h81,
    8'h81, 8'hA1, 8'h81, 8'h80, 8'h81, 8'h90, 8'h82};
  localparam logic [7:0] AI [12] = '{8'h80, 8'hC0, 8'hA0, 8'hA0, 8'h90,
    8'h80, 8'h88, 8'h88, 8'hC6, 8'h96, 8'h20, 8'hA0};
  localparam aosm_tb_smp_t AL [12] = '{FA, FL, FA, FB, NL, NL, NR, NL, FA,
    FA, FL, FL};
  localparam aosm_tb_smp_t AR [12] = '{FA, FR, FA, FB, NR, NL, NR, NL, FA,
    FA, FL, NL};
  localparam logic [11:0] AA = 12'h3FF;
  localparam logic [7:0] LC [4] = '{8'h0F, 8'h10, 8'h1F, 8'h03};
  localparam logic [14:0] LF [4] = '{15'h59FA, 15'h02D8, 15'h1000, 15'h169A};
  localparam logic [7:0] MS [12] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h02,
    8'h03, 8'h03, 8'h02, 8'h03, 8'h08, 8'h80, 8'h88};
  localparam logic [7:0] MI [12] = '{8'h40, 8'h20, 8'h40, 8'h10, 8'h00,
    8'h08, 8'h00, 8'h08, 8'h18, 8'h00, 8'h00, 8'h00};
  localparam aosm_tb_smp_t MV [12] = '{FA, FB, FA, 16'h0600, NL, NR, NL, NL,
    NR, FA, FA, FA};
  localparam logic [14:0] MF [12] = '{15'h1000, 15'h1000, 15'h1000,
    15'h1000, 15'h1000, 15'h1000, 15'h1000, 15'h1000, 15'h1000, 15'h169A,
    15'h1FED, 15'h2D18};

  logic                    sys_clk_in;
  logic                    rst_n_in;
  logic                    reg_wr_en_in;
  logic                    reg_rd_en_in;
  logic [7:0]              reg_addr_in;
  logic [7:0]              reg_wdata_in;
  logic [7:0]              reg_rdata_out;
  aosm_pkg::aosm_samples_t samples_in;
  logic                    sample_valid_in;
  aosm_pkg::aosm_ident_t   ident_in;
  aosm_pkg::aosm_audio_t   audio_out;
  aosm_pkg::aosm_audio_t   cap;
  logic                    audio_valid_out;
  logic                    serial_auto_active_out;
  logic [15:0]             cap_count;
  int                      fail_count;
  int                      samples_checked;
  int                      cycles;
  int                      n_sent;

  aosm_matrix DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .reg_wr_en_in(reg_wr_en_in), .reg_rd_en_in(reg_rd_en_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .samples_in(samples_in),
    .sample_valid_in(sample_valid_in), .ident_in(ident_in),
    .audio_out(audio_out), .audio_valid_out(audio_valid_out),
    .serial_auto_active_out(serial_auto_active_out));
  aosm_audio_sink u_sink (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .audio_in(audio_out), .valid_in(audio_valid_out), .last_out(cap),
    .count_out(cap_count));

  function automatic aosm_tb_smp_t gain(input aosm_tb_smp_t s,
                                        input logic [14:0] f);
    int p;
    p = int'(s) * int'(f);
    return aosm_tb_smp_t'(p >>> aosm_pkg::GAIN_FRAC);
  endfunction : gain

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    reg_wr_en_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge sys_clk_in);
    reg_wr_en_in = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk_in);
    reg_rd_en_in = 1'b1;
    reg_addr_in = a;
    @(negedge sys_clk_in);
    reg_rd_en_in = 1'b0;
    `CHK(reg_rdata_out, e, "register read")
  endtask : reg_rd

  task automatic play(input logic [7:0] id, input aosm_tb_smp_t el,
                      input aosm_tb_smp_t er, input aosm_tb_smp_t em);
    @(negedge sys_clk_in);
    ident_in = id;
    sample_valid_in = 1'b1;
    n_sent++;
    @(negedge sys_clk_in);
    sample_valid_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    `CHK(cap.left, el, "left output")
    `CHK(cap.right, er, "right output")
    `CHK(cap.mono, em, "mono output")
  endtask : play

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  // Cut a hang short
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 16'h0FA0) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    rst_n_in = 1'b0;
    reg_wr_en_in = 1'b0;
    reg_rd_en_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    samples_in = {FL, FR, FA, FB, NL, NR};
    sample_valid_in = 1'b0;
    ident_in = 8'h00;
    repeat (6) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    reg_rd(8'h16, 8'h00);
    reg_rd(8'h17, 8'h00);
    reg_rd(8'h18, aosm_pkg::RST_MONO_SEL);
    reg_rd(8'h20, 8'hFF);
    reg_wr(8'h17, 8'hFF);
    reg_rd(8'h17, 8'h1F);
    reg_wr(8'h18, 8'hFF);
    reg_rd(8'h18, 8'h8B);
    reg_wr(8'h17, 8'h00);
    reg_wr(8'h18, 8'h00);
    $display("test registers done");
    for (int m = 0; m < 8; m++) begin
      reg_wr(8'h16, {1'b0, 3'(m), 4'h0});
      play(8'h40, ML[m], MR[m], FA);
    end
    $display("test manual modes done");
    for (int s = 0; s < 4; s++) begin
      reg_wr(8'h16, {6'h00, 2'(s)});
      play(8'hC0, SL[s], SR[s], FA);
    end
    $display("test sources done");
    for (int i = 0; i < 12; i++) begin
      reg_wr(8'h16, AS[i]);
      play(AI[i], AL[i], AR[i], FA);
      `CHK(serial_auto_active_out, AA[i], "auto flag")
    end
    $display("test auto select done");
    reg_wr(8'h16, 8'h00);
    for (int i = 0; i < 4; i++) begin
      reg_wr(8'h17, LC[i]);
      play(8'h40, gain(FL, LF[i]), gain(FR, LF[i]), FA);
    end
    reg_wr(8'h17, 8'h00);
    $display("test level done");
    for (int i = 0; i < 12; i++) begin
      reg_wr(8'h18, MS[i]);
      play(MI[i], FL, FR, gain(MV[i], MF[i]));
    end
    $display("test mono converter done");
    `CHK(cap_count, 16'(n_sent), "sample count")
    give_verdict();
  end
endmodule : test_audio_output_source_matrix
